//--- include/session_pkg.sv
// Session register bank constants, field layouts and carrier structs.
// Assumes a single 25 MHz clock domain; shared by the design and its bench.
package session_pkg;

  // Register indices on the session register port
  localparam logic [2:0] IDX_CONTROL     = 3'h0;
  localparam logic [2:0] IDX_LAST_BLOCK  = 3'h1;
  localparam logic [2:0] IDX_MIRROR_BLK  = 3'h2;
  localparam logic [2:0] IDX_WDT_LOW     = 3'h3;
  localparam logic [2:0] IDX_WDT_HIGH    = 3'h4;
  localparam logic [2:0] IDX_AUTH_STRETCH = 3'h5;
  localparam logic [2:0] IDX_STATUS      = 3'h6;

  // Control byte fields
  localparam int CTL_SILENCE_BIT = 7;
  localparam int CTL_PTHRU_BIT   = 6;
  localparam int CTL_FDOFF_LSB   = 4;
  localparam int CTL_FDON_LSB    = 2;
  localparam int CTL_MIRROR_BIT  = 1;
  localparam int CTL_DIR_BIT     = 0;

  // Status byte fields
  localparam int ST_MSG_DONE   = 7;
  localparam int ST_HOST_LOCK  = 6;
  localparam int ST_CL_LOCK    = 5;
  localparam int ST_HOST_READY = 4;
  localparam int ST_CL_READY   = 3;
  localparam int ST_WR_ERR     = 2;
  localparam int ST_WR_BUSY    = 1;
  localparam int ST_FIELD      = 0;

  // Auth/stretch byte fields
  localparam int AS_EXHAUSTED  = 1;
  localparam int AS_STRETCH    = 0;

  // Reset values (session copies load from configuration at power-up)
  localparam logic [7:0] RST_CONTROL    = 8'h01;
  localparam logic [7:0] RST_LAST_BLOCK = 8'h00;
  localparam logic [7:0] RST_MIRROR_BLK = 8'hf8;
  localparam logic [7:0] RST_WDT_LOW    = 8'h48;
  localparam logic [7:0] RST_WDT_HIGH   = 8'h08;
  localparam logic [7:0] ZERO_BYTE      = 8'h00;

  // Field-detect assert and release selections
  localparam logic [1:0] FD_SEL_FIELD  = 2'h0;
  localparam logic [1:0] FD_SEL_SOC    = 2'h1;
  localparam logic [1:0] FD_SEL_MSG    = 2'h2;
  localparam logic [1:0] FD_SEL_PTHRU  = 2'h3;

  // Host-side register access request
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [2:0] idx;
    logic [7:0] wdata;
  } host_req_s;

  // Contactless-side events, one-cycle pulses except field
  typedef struct packed {
    logic field;
    logic valid_cmd;
    logic selected;
    logic halted;
    logic last_block_read;
    logic sram_written;
    logic sram_read_done;
    logic rd;
    logic wr;
    logic [2:0] idx;
  } cl_evt_s;

  // Memory-core status levels and pulses
  typedef struct packed {
    logic auth_exhausted;
    logic hv_error;
    logic wr_busy;
    logic host_ready;
    logic cl_ready;
    logic cl_lock;
    logic host_on;
    logic cl_on;
    logic vcc_present;
    logic wdt_expired;
    logic host_comm_active;
  } core_st_s;

endpackage : session_pkg

//--- rtl/session_status_field_detect.sv
// Session register bank with status byte and open-drain field-detect pin.
// Assumes host and contactless ports are already decoded into the ref_clk
// domain; field, vcc and the host_on/cl_on core levels arrive asynchronously and are synced.
`timescale 1ns/1ps
`default_nettype none

module session_status_field_detect
  import session_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       clk_en,
  input  wire host_req_s  host_req,
  output logic      [7:0] host_rdata,
  input  wire cl_evt_s    cl_evt,
  output logic      [7:0] cl_rdata,
  input  wire core_st_s   core_st,
  input  wire logic       cfg_stretch,
  output logic     [15:0] wdt_active,
  output logic      [7:0] last_block,
  output logic      [7:0] mirror_block,
  output logic            fd_out,
  output logic            fd_oe_n
);

  // Two-flop synchronisers for asynchronous levels
  // Only the second flop is read by logic, so a metastable first stage never escapes
  // clk_en freezes these too, so a frozen block sees no level change at all
  logic [3:0] async_in;
  logic [3:0] sync1_r;
  logic [3:0] sync2_r;
  assign async_in = {cl_evt.field, core_st.vcc_present, core_st.host_on, core_st.cl_on};

  generate
    for (genvar g = 0; g < 4; g++)
    begin : g_sync
      always_ff @(posedge ref_clk or posedge rst)
      begin
        if (rst)
        begin
          sync1_r[g] <= 1'b0;
          sync2_r[g] <= 1'b0;
        end
        else if (clk_en)
        begin
          sync1_r[g] <= async_in[g];
          sync2_r[g] <= sync1_r[g];
        end
      end
    end
  endgenerate

  logic field_s;
  logic vcc_s;
  logic host_on_s;
  logic cl_on_s;
  assign field_s   = sync2_r[3];
  assign vcc_s     = sync2_r[2];
  assign host_on_s = sync2_r[1];
  assign cl_on_s   = sync2_r[0];

  logic [7:0]  control_r;
  logic [7:0]  last_block_r;
  logic [7:0]  mirror_r;
  logic [7:0]  wdt_low_r;
  logic [7:0]  wdt_high_r;
  logic [15:0] wdt_active_r;
  logic        msg_done_r;
  logic        host_lock_r;
  logic        wr_err_r;
  logic        fd_low_r;
  logic        field_d_r;
  logic        msg_done_rd_r;

  // Host accesses; the contactless port has no write path at all
  logic host_wr;
  logic host_rd;
  logic status_rd;
  assign host_wr   = host_req.wr;
  assign host_rd   = host_req.rd;
  assign status_rd = host_rd && (host_req.idx == IDX_STATUS);

  // Control byte with automatic clearing of the two enables
  // The clears repeat every cycle the condition lasts, so a host write cannot re-arm them
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      control_r <= RST_CONTROL;
    else if (clk_en)
    begin
      if (host_wr && host_req.idx == IDX_CONTROL)
        control_r <= host_req.wdata;
      // Hardware clear wins over a same-cycle host write
      if (!host_on_s || !cl_on_s)
        control_r[CTL_PTHRU_BIT] <= 1'b0;
      if (!vcc_s)
        control_r[CTL_MIRROR_BIT] <= 1'b0;
    end
  end

  // Block address bytes
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      last_block_r <= RST_LAST_BLOCK;
      mirror_r     <= RST_MIRROR_BLK;
    end
    else if (clk_en && host_wr)
    begin
      if (host_req.idx == IDX_LAST_BLOCK)
        last_block_r <= host_req.wdata;
      else if (host_req.idx == IDX_MIRROR_BLK)
        mirror_r <= host_req.wdata;
    end
  end

  // Watchdog bytes: the low byte is only staged until the high byte lands
  // The timer never sees a half-updated pair, at the cost of one extra host write
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      wdt_low_r    <= RST_WDT_LOW;
      wdt_high_r   <= RST_WDT_HIGH;
      wdt_active_r <= {RST_WDT_HIGH, RST_WDT_LOW};
    end
    else if (clk_en && host_wr)
    begin
      if (host_req.idx == IDX_WDT_LOW)
        wdt_low_r <= host_req.wdata;
      else if (host_req.idx == IDX_WDT_HIGH)
      begin
        wdt_high_r   <= host_req.wdata;
        wdt_active_r <= {host_req.wdata, wdt_low_r};
      end
    end
  end

  // Message-read-done: set by the last block read, cleared by a status read
  // A last-block read in the same cycle as a status read keeps the bit, so it is not lost
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      msg_done_r <= 1'b0;
    else if (clk_en)
    begin
      if (cl_evt.last_block_read)
        msg_done_r <= 1'b1;
      else if (status_rd)
        msg_done_r <= 1'b0;
    end
  end

  // Host lock: host writes it, watchdog expiry clears it once traffic ends
  // An expiry pulse seen while the host is still talking is dropped; the core must resend it
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      host_lock_r <= 1'b0;
    else if (clk_en)
    begin
      if (host_wr && host_req.idx == IDX_STATUS)
        host_lock_r <= host_req.wdata[ST_HOST_LOCK];
      else if (core_st.wdt_expired && !core_st.host_comm_active)
        host_lock_r <= 1'b0;
    end
  end

  // Write-error flag is sticky; a new error beats a same-cycle clear
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      wr_err_r <= 1'b0;
    else if (clk_en)
    begin
      if (core_st.hv_error)
        wr_err_r <= 1'b1;
      else if (host_wr && host_req.idx == IDX_STATUS && !host_req.wdata[ST_WR_ERR])
        wr_err_r <= 1'b0;
    end
  end

  // Status and auth bytes assembled from live state
  // Rebuilt every cycle, so read-only bits cannot be written by either side
  logic [7:0] status_byte;
  logic [7:0] auth_byte;
  always_comb
  begin
    status_byte               = ZERO_BYTE;
    status_byte[ST_MSG_DONE]  = msg_done_r;
    status_byte[ST_HOST_LOCK] = host_lock_r;
    status_byte[ST_CL_LOCK]   = core_st.cl_lock;
    status_byte[ST_HOST_READY] = core_st.host_ready;
    status_byte[ST_CL_READY]  = core_st.cl_ready;
    status_byte[ST_WR_ERR]    = wr_err_r;
    status_byte[ST_WR_BUSY]   = core_st.wr_busy;
    status_byte[ST_FIELD]     = field_s;
    auth_byte                 = ZERO_BYTE;
    auth_byte[AS_EXHAUSTED]   = core_st.auth_exhausted;
    auth_byte[AS_STRETCH]     = cfg_stretch;
  end

  // Shared read mux for both ports
  // Unused indices read as zero rather than aliasing a real register
  function automatic logic [7:0] read_mux(input logic [2:0] idx,
                                          input logic [7:0] st,
                                          input logic [7:0] au);
    logic [7:0] v;
    v = ZERO_BYTE;
    if (idx == IDX_CONTROL)
      v = control_r;
    else if (idx == IDX_LAST_BLOCK)
      v = last_block_r;
    else if (idx == IDX_MIRROR_BLK)
      v = mirror_r;
    else if (idx == IDX_WDT_LOW)
      v = wdt_low_r;
    else if (idx == IDX_WDT_HIGH)
      v = wdt_high_r;
    else if (idx == IDX_AUTH_STRETCH)
      v = au;
    else if (idx == IDX_STATUS)
      v = st;
    return v;
  endfunction : read_mux

  // Registered read data, one cycle after the read strobe
  // Separate registers so a contactless read never disturbs host read data
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      host_rdata <= ZERO_BYTE;
      cl_rdata   <= ZERO_BYTE;
    end
    else if (clk_en)
    begin
      if (host_rd)
        host_rdata <= read_mux(host_req.idx, status_byte, auth_byte);
      if (cl_evt.rd)
        cl_rdata <= read_mux(cl_evt.idx, status_byte, auth_byte);
    end
  end

  // Field-detect engine; driven by contactless events, field power, host status reads and core ready levels
  // Field rise comes from the synchronised level, so it lags the pin by two cycles
  // Every release term includes field loss: without a field the pin has no power
  logic [1:0] fd_assert_select_sel;
  logic [1:0] fd_release_select_sel;
  logic       field_rise;
  logic       pthru;
  logic       assert_ev;
  logic       release_ev;
  assign fd_assert_select_sel  = control_r[CTL_FDON_LSB +: 2];
  assign fd_release_select_sel = control_r[CTL_FDOFF_LSB +: 2];
  assign field_rise = field_s && !field_d_r;
  assign pthru      = control_r[CTL_PTHRU_BIT];

  always_comb
  begin
    assign_default:
    begin
      assert_ev  = 1'b0;
      release_ev = 1'b0;
    end
    case (fd_assert_select_sel)
      FD_SEL_FIELD: assert_ev = field_rise || (msg_done_rd_r && field_s);
      FD_SEL_SOC:   assert_ev = cl_evt.valid_cmd;
      FD_SEL_MSG:   assert_ev = cl_evt.selected;
      default:      assert_ev = pthru ? (cl_evt.sram_written || cl_evt.sram_read_done)
                                      : cl_evt.selected;
    endcase
    case (fd_release_select_sel)
      FD_SEL_FIELD: release_ev = !field_s;
      FD_SEL_SOC:   release_ev = !field_s || cl_evt.halted;
      FD_SEL_MSG:   release_ev = !field_s || cl_evt.last_block_read;
      default:      release_ev = !field_s || (pthru ? (core_st.host_ready == 1'b0 && core_st.cl_ready == 1'b0)
                                                     : cl_evt.halted);
    endcase
  end

  // With the FD_SEL_FIELD assert select, a host read of a set message-done bit re-arms the low level
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      field_d_r     <= 1'b0;
      msg_done_rd_r <= 1'b0;
    end
    else if (clk_en)
    begin
      field_d_r     <= field_s;
      msg_done_rd_r <= status_rd && msg_done_r;
    end
  end

  // Pin state; assertion wins over release in the same cycle
  // Priority to assertion means a pass-through event is never lost to a stale release
  // Reset leaves the pin released, matching the external pull-up's idle level
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      fd_low_r <= 1'b0;
    else if (clk_en)
    begin
      if (assert_ev)
        fd_low_r <= 1'b1;
      else if (release_ev)
        fd_low_r <= 1'b0;
    end
  end

  // Open drain: output is always zero, only the enable moves
  assign fd_out  = 1'b0;
  assign fd_oe_n = !fd_low_r;

  assign wdt_active   = wdt_active_r;
  assign last_block   = last_block_r;
  assign mirror_block = mirror_r;

endmodule : session_status_field_detect

`default_nettype wire

//--- verif/reader_model.sv
// Contactless reader stand-in: turns bench event codes into the event carrier.
// Assumes codes change at falling edges, so pulses span one full cycle.
`timescale 1ns/1ps
`default_nettype none
module reader_model
  import session_pkg::*;
(
  input  wire logic       field_on,
  input  wire logic [3:0] ev_code,
  input  wire logic [2:0] ev_idx,
  output var  cl_evt_s    cl_evt
);
  // One code per cycle: a reader never issues two events at once
  always_comb
  begin
    cl_evt                 = '0;
    cl_evt.field           = field_on;
    cl_evt.valid_cmd       = (ev_code == 4'h1);
    cl_evt.selected        = (ev_code == 4'h2);
    cl_evt.halted          = (ev_code == 4'h3);
    cl_evt.last_block_read = (ev_code == 4'h4);
    cl_evt.sram_written    = (ev_code == 4'h5);
    cl_evt.sram_read_done  = (ev_code == 4'h6);
    cl_evt.wr              = (ev_code == 4'h7); // Only sent when a write must be refused
    cl_evt.rd              = (ev_code == 4'h8);
    cl_evt.idx             = ev_idx;
  end
endmodule : reader_model
`default_nettype wire

//--- verif/session_checker_assertions.sv
// Port checker for the session register bank and field-detect pin.
// Assumes one ref_clk domain; bound to the top module below.
`timescale 1ns/1ps
`default_nettype none
module session_checker
  import session_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic        clk_en,
  input wire host_req_s   host_req,
  input wire logic [7:0]  host_rdata,
  input wire cl_evt_s     cl_evt,
  input wire core_st_s    core_st,
  input wire logic [15:0] wdt_active,
  input wire logic [7:0]  last_block,
  input wire logic [7:0]  mirror_block,
  input wire logic        fd_out,
  input wire logic        fd_oe_n
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic [7:0] ctl_r;
  // Shadow of the control byte; hardware only clears bits 6 and 1, so the selects stay exact
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
      ctl_r <= RST_CONTROL;
    else if (clk_en && host_req.wr && host_req.idx == IDX_CONTROL)
      ctl_r <= host_req.wdata;
  sequence auth_rd;
    clk_en && host_req.rd && host_req.idx == IDX_AUTH_STRETCH;
  endsequence
  sequence exhausted_rd;
    core_st.auth_exhausted [*3] ##0 auth_rd;
  endsequence
  sequence field_gone;
    !cl_evt.field [*5];
  endsequence
  a_fd_never_high: assert property (fd_out == 1'b0) else $error("fd driven high");
  a_auth_upper_zero: assert property (auth_rd |=> host_rdata[7:2] == 6'h00) else $error("auth rfu set");
  a_auth_exhaust_bit: assert property (exhausted_rd |=> host_rdata[AS_EXHAUSTED]) else $error("exhaust bit");
  a_wdt_low_held: assert property (clk_en && host_req.wr && host_req.idx == IDX_WDT_LOW |=> $stable(wdt_active))
    else $error("wdt applied early");
  a_wdt_high_apply: assert property (clk_en && host_req.wr && host_req.idx == IDX_WDT_HIGH
    |=> wdt_active[15:8] == $past(host_req.wdata)) else $error("wdt not applied");
  a_fd_release_field: assert property (field_gone |-> fd_oe_n) else $error("fd held without field");
  a_fd_assert_cmd: assert property (clk_en && ctl_r[CTL_FDON_LSB +: 2] == FD_SEL_SOC && cl_evt.valid_cmd |=> !fd_oe_n)
    else $error("fd not pulled on command");
  a_cl_write_ignored: assert property (cl_evt.wr && !host_req.wr |=> $stable(last_block) && $stable(mirror_block))
    else $error("contactless write took");
endmodule : session_checker
bind session_status_field_detect session_checker chk (.ref_clk(ref_clk), .rst(rst), .clk_en(clk_en),
  .host_req(host_req), .host_rdata(host_rdata), .cl_evt(cl_evt), .core_st(core_st), .wdt_active(wdt_active),
  .last_block(last_block), .mirror_block(mirror_block), .fd_out(fd_out), .fd_oe_n(fd_oe_n));
`default_nettype wire

//--- verif/session_status_field_detect_tb.sv
// Self-checking bench for the session register bank and field-detect pin.
// Assumes the reader model and the bound checker are compiled alongside.
`timescale 1ns/1ps
`default_nettype none
module session_status_field_detect_tb import session_pkg::*;;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        clk_en = 1'b1;
  host_req_s   host_req = '0;
  core_st_s    core_st = '0;
  logic        field_on = 1'b0;
  logic [3:0]  ev_code = 4'h0;
  logic [2:0]  ev_idx = IDX_MIRROR_BLK;
  cl_evt_s     cl_evt;
  logic [7:0]  host_rdata, cl_rdata, last_block, mirror_block;
  logic [15:0] wdt_active;
  logic        fd_out, fd_oe_n;
  int          failures = 0;
  int          checks_done = 0;
  logic [7:0]  rv [5] = '{RST_CONTROL, RST_LAST_BLOCK, RST_MIRROR_BLK, RST_WDT_LOW, RST_WDT_HIGH};
  logic [7:0]  fd_tab [4][3] = '{'{8'h14, 8'h1, 8'h3}, '{8'h28, 8'h2, 8'h4}, '{8'h5c, 8'h5, 8'h3}, '{8'h5c, 8'h6, 8'h3}};
  always #20 ref_clk = ~ref_clk;
  session_status_field_detect uut (.ref_clk(ref_clk), .rst(rst), .clk_en(clk_en), .host_req(host_req),
    .host_rdata(host_rdata), .cl_evt(cl_evt), .cl_rdata(cl_rdata), .core_st(core_st), .cfg_stretch(1'b1),
    .wdt_active(wdt_active), .last_block(last_block), .mirror_block(mirror_block), .fd_out(fd_out),
    .fd_oe_n(fd_oe_n));
  reader_model reader (.field_on(field_on), .ev_code(ev_code), .ev_idx(ev_idx), .cl_evt(cl_evt));
  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  task automatic idle(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : idle
  // Host strobes last one cycle, launched and dropped at falling edges
  task automatic host_wr(input logic [2:0] idx, input logic [7:0] d);
    @(negedge ref_clk);
    host_req = '{rd: 1'b0, wr: 1'b1, idx: idx, wdata: d};
    @(negedge ref_clk);
    host_req.wr = 1'b0;
  endtask : host_wr
  task automatic host_rd(input logic [2:0] idx, input logic [7:0] exp, input string name);
    @(negedge ref_clk);
    host_req.rd = 1'b1;
    host_req.idx = idx;
    @(negedge ref_clk);
    host_req.rd = 1'b0;
    check(name, {8'h00, exp}, {8'h00, host_rdata});
  endtask : host_rd
  task automatic cl_event(input logic [3:0] code);
    @(negedge ref_clk);
    ev_code = code;
    @(negedge ref_clk);
    ev_code = 4'h0;
  endtask : cl_event
  // Core pulses: hv error or watchdog expiry, one cycle wide
  task automatic core_pulse(input logic hv);
    @(negedge ref_clk);
    core_st.hv_error = hv;
    core_st.wdt_expired = !hv;
    @(negedge ref_clk);
    core_st.hv_error = 1'b0;
    core_st.wdt_expired = 1'b0;
  endtask : core_pulse
  task automatic t_reset_auth;
    for (int i = 0; i < 5; i++)
      host_rd(3'(i), rv[i], "reset value");
    check("wdt_active", 16'h0848, wdt_active);
    host_rd(IDX_AUTH_STRETCH, 8'h01, "auth byte");
    core_st.auth_exhausted = 1'b1;
    idle(3);
    host_rd(IDX_AUTH_STRETCH, 8'h03, "auth byte");
  endtask : t_reset_auth
  task automatic t_watchdog;
    host_wr(IDX_WDT_LOW, 8'h34);
    check("wdt_active", 16'h0848, wdt_active);
    host_wr(IDX_WDT_HIGH, 8'h12);
    check("wdt_active", 16'h1234, wdt_active);
    host_wr(IDX_LAST_BLOCK, 8'h37);
    check("last_block", 16'h0037, {8'h00, last_block});
  endtask : t_watchdog
  task automatic t_autoclear;
    core_st.vcc_present = 1'b1;
    core_st.host_on = 1'b1;
    core_st.cl_on = 1'b1;
    idle(4);
    host_wr(IDX_CONTROL, 8'hc2);
    host_rd(IDX_CONTROL, 8'hc2, "control");
    core_st.cl_on = 1'b0;
    idle(4);
    host_rd(IDX_CONTROL, 8'h82, "control");
    core_st.vcc_present = 1'b0;
    idle(4);
    host_rd(IDX_CONTROL, 8'h80, "control");
    core_st.vcc_present = 1'b1;
    core_st.cl_on = 1'b1;
  endtask : t_autoclear
  task automatic t_status;
    core_st.wr_busy = 1'b1;
    core_st.host_ready = 1'b1;
    core_st.cl_lock = 1'b1;
    field_on = 1'b1;
    idle(4);
    host_rd(IDX_STATUS, 8'h33, "status");
    core_st.wr_busy = 1'b0;
    core_st.host_ready = 1'b0;
    core_st.cl_ready = 1'b1;
    idle(3);
    host_rd(IDX_STATUS, 8'h29, "status");
    host_wr(IDX_STATUS, 8'h40);
    host_rd(IDX_STATUS, 8'h69, "status");
    core_pulse(1'b1);
    host_wr(IDX_STATUS, 8'h44);
    host_rd(IDX_STATUS, 8'h6d, "status");
    host_wr(IDX_STATUS, 8'h40);
    host_rd(IDX_STATUS, 8'h69, "status");
    core_pulse(1'b0);
    idle(2);
    host_rd(IDX_STATUS, 8'h29, "status");
  endtask : t_status
  // Field trigger with message release, then re-low on the host's status read
  task automatic t_field_msg;
    host_wr(IDX_CONTROL, 8'h20);
    core_st.vcc_present = 1'b0; // Host supply off: the pin must still work
    field_on = 1'b0;
    idle(6);
    check("fd_oe_n", 16'h1, {15'h0, fd_oe_n});
    field_on = 1'b1;
    idle(5);
    check("fd_oe_n", 16'h0, {15'h0, fd_oe_n});
    check("fd_out", 16'h0, {15'h0, fd_out});
    cl_event(4'h4);
    idle(2);
    check("fd_oe_n", 16'h1, {15'h0, fd_oe_n});
    host_rd(IDX_STATUS, 8'ha9, "status");
    idle(3);
    check("fd_oe_n", 16'h0, {15'h0, fd_oe_n});
    host_rd(IDX_STATUS, 8'h29, "status");
    core_st.vcc_present = 1'b1;
  endtask : t_field_msg
  task automatic t_fd_table;
    for (int i = 0; i < 4; i++)
    begin
      host_wr(IDX_CONTROL, fd_tab[i][0]);
      cl_event(fd_tab[i][2][3:0]);
      idle(2);
      check("fd_oe_n", 16'h1, {15'h0, fd_oe_n});
      cl_event(fd_tab[i][1][3:0]);
      idle(2);
      check("fd_oe_n", 16'h0, {15'h0, fd_oe_n});
      cl_event(fd_tab[i][2][3:0]);
      idle(2);
      check("fd_oe_n", 16'h1, {15'h0, fd_oe_n});
    end
    // Pass-through release: held while a buffer is ready, released once both drain
    host_wr(IDX_CONTROL, 8'h7c);
    cl_event(4'h5);
    idle(2);
    check("fd_oe_n", 16'h0, {15'h0, fd_oe_n});
    core_st.cl_ready = 1'b0;
    idle(2);
    check("fd_oe_n", 16'h1, {15'h0, fd_oe_n});
    core_st.cl_ready = 1'b1;
  endtask : t_fd_table
  task automatic t_cl_refused;
    clk_en = 1'b0;
    host_wr(IDX_MIRROR_BLK, 8'h11);
    clk_en = 1'b1;
    check("mirror_block", 16'h00f8, {8'h00, mirror_block});
    cl_event(4'h8);
    check("cl_rdata", 16'h00f8, {8'h00, cl_rdata});
    cl_event(4'h7);
    idle(2);
    check("mirror_block", 16'h00f8, {8'h00, mirror_block});
    cl_event(4'h8);
    check("cl_rdata", 16'h00f8, {8'h00, cl_rdata});
  endtask : t_cl_refused
  task automatic tally_and_finish;
    if (failures == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish
  // Whole run is under two thousand cycles; this limit only cuts a hang
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    failures++;
    tally_and_finish();
  end
  initial
  begin
    repeat (12) @(posedge ref_clk);
    @(negedge ref_clk);
    rst = 1'b0;
    t_reset_auth();
    t_watchdog();
    t_autoclear();
    t_status();
    t_field_msg();
    t_fd_table();
    t_cl_refused();
    tally_and_finish();
  end
endmodule : session_status_field_detect_tb
`default_nettype wire
